/* src/osp_params.svh */
// Register offsets, field positions, reset values and widths of the pulse block.
`ifndef OSP_PARAMS_SVH
`define OSP_PARAMS_SVH

`define OSP_ADR_OUT_EN 8'h00
`define OSP_ADR_OUT_BITS 8'h04
`define OSP_ADR_PORT_DIR 8'h08
`define OSP_ADR_IRQ_REQ 8'h0c
`define OSP_ADR_IRQ_MASK 8'h10
`define OSP_ADR_START 8'h14
`define OSP_ADR_STATUS 8'h18
`define OSP_ADR_CH0_DATA 8'h1c
`define OSP_ADR_CH3_DATA 8'h20
`define OSP_ADR_MODE 8'h24
`define OSP_ADR_CH0_COUNT 8'h28
`define OSP_ADR_CH3_COUNT 8'h2c

`define OSP_BIT_CH0 0
`define OSP_BIT_CH3 3
`define OSP_BIT_PIN31 1
`define OSP_BIT_CH0_IRQ 4
`define OSP_BIT_MODE_CH0_RETRIG 0
`define OSP_BIT_MODE_CH3_RETRIG 1
`define OSP_BIT_STAT_CH0_BUSY 4
`define OSP_BIT_STAT_CH3_BUSY 5
`define OSP_BIT_STAT_PIN_LEVEL 8

`define OSP_RST_OUT_EN 1'b0
`define OSP_RST_OUT_BIT 1'b0
`define OSP_RST_PORT_DIR 8'hff
`define OSP_RST_IRQ_REQ 8'h00
`define OSP_RST_IRQ_MASK 8'hff
`define OSP_RST_DATA 16'h0000
`define OSP_RST_RETRIG 1'b0

`define OSP_CNT_W 16
`define OSP_NUM_CH 2

`endif

/* src/osp_pkg.sv */
// Types shared by the one-shot pulse output block.
package osp_pkg;

	// State of the register and output control logic.
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic oe0;
		logic oe3;
		logic to0;
		logic to3;
		logic [7:0] pm3;
		logic [7:0] irq_request_flags_low;
		logic [7:0] irq_mask_flags_low;
		logic te0;
		logic te3;
		logic [15:0] data0;
		logic [15:0] data3;
		logic retrig0;
		logic retrig3;
		logic trig0;
	} osp_state_t;

	// State of one one-count down counter.
	typedef struct packed {
		logic busy;
		logic done;
		logic [15:0] cnt;
	} osp_chan_state_t;

	// State of a two-stage synchroniser.
	typedef struct packed {
		logic s1;
		logic s2;
	} osp_sync_state_t;

endpackage

/* src/osp_sync.sv */
// Two-flop synchroniser for a level arriving from a pin.
`timescale 1ns/10ps
module osp_sync import osp_pkg::*; (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Asynchronous level in, synchronised level out.
	input wire logic d,
	output logic q
);
	osp_sync_state_t st_reg;
	osp_sync_state_t st_next;

	always_comb begin
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;
endmodule

/* src/osp_channel.sv */
// One-count down counter of one timer channel.
`timescale 1ns/10ps
`include "osp_params.svh"
module osp_channel import osp_pkg::*; #(
	parameter int W = `OSP_CNT_W
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Control.
	input wire logic start,
	input wire logic retrig_ok,
	input wire logic [W-1:0] load,
	// Status.
	output logic busy,
	output logic done,
	output logic [W-1:0] count
);
	osp_chan_state_t st_reg;
	osp_chan_state_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		// A trigger while busy restarts only when retrigger is on.
		if (start && (!st_reg.busy || retrig_ok)) begin // R11 R14
			st_next.cnt = 16'(load);
			st_next.busy = 1'b1;
			st_next.done = st_reg.busy;
		end else if (st_reg.busy) begin
			if (st_reg.cnt == 16'h0000) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy = st_reg.busy;
	assign done = st_reg.done;
	assign count = W'(st_reg.cnt);
endmodule

/* src/osp_top.sv */
// Output and start control of a two-channel one-shot pulse generator.
// Operation
// R1 - A delay channel and a width channel together make one pulse.
// R2 - With output enable clear, counting leaves the output bit alone.
// R3 - With output enable set, counting drives the bit; writes are ignored.
// R4 - Output enable of channel n sits at bit n, so bits 0 and 3.
// R5 - Direction bit 0 drives the pin, 1 releases it as input.
// R6 - The master interrupt flag reads 1 while a request is pending.
// R7 - Software clears the master interrupt flag before starting.
// R8 - The master mask passes the interrupt at 0 and blocks it at 1.
// R9 - Writing 1 to the slave start bit sets its run flag.
// R10 - Writing 1 to the master start bit sets its run flag.
// R11 - Counting starts at the moment the channel mode sets.
// R12 - Software starts both channels with one write.
// R13 - The slave channel pin carries the one-shot pulse.
// R14 - Without retrigger a trigger during counting is ignored, no irq.
// R15 - Slave output set on master interrupt, reset on its own.
// R16 - The slave starts counting and goes active on the master irq.
// R17 - The pin shows the pulse only if enabled and in output mode.
`timescale 1ns/10ps
`include "osp_params.svh"
module osp_top import osp_pkg::*; #(
	parameter int CNT_W = `OSP_CNT_W
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pulse output pin.
	input wire logic pulse_output_pin_i,
	output logic pulse_output_pin_o,
	output logic pulse_output_pin_oe,
	// Master channel output and interrupt.
	output logic ch0_output_bit,
	output logic ch0_irq_o
);
	osp_state_t st_reg;
	osp_state_t st_next;

	logic [`OSP_NUM_CH-1:0] ch_start;
	logic [`OSP_NUM_CH-1:0] ch_retrig;
	logic [`OSP_NUM_CH-1:0] ch_busy;
	logic [`OSP_NUM_CH-1:0] ch_done;
	logic [CNT_W-1:0] ch_load [`OSP_NUM_CH];
	logic [CNT_W-1:0] ch_count [`OSP_NUM_CH];
	logic ch0_timer_interrupt;
	logic ch3_timer_interrupt;
	logic pin_level;
	logic req;
	logic wr_now;
	logic [7:0] adr;
	logic [31:0] wmask;
	logic [31:0] wdat;

	// Level on the pin, read back while it is an input.
	osp_sync u_pin_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(pulse_output_pin_i),
		.q(pin_level)
	);

	// Index 0 is the delay channel, index 1 the width channel.
	assign ch_load[0] = CNT_W'(st_reg.data0);
	assign ch_load[1] = CNT_W'(st_reg.data3);
	assign ch_retrig[0] = st_reg.retrig0;
	assign ch_retrig[1] = st_reg.retrig3;
	// The delay channel starts on its software trigger.
	assign ch_start[0] = st_reg.trig0 && st_reg.te0; // R10 R11
	// The width channel starts on the delay channel's interrupt.
	assign ch_start[1] = ch0_timer_interrupt && st_reg.te3; // R1 R16

	generate
		for (genvar g = 0; g < `OSP_NUM_CH; g++) begin : g_ch
			osp_channel #(
				.W(CNT_W)
			) u_ch (
				.clk(clk),
				.sys_rst(sys_rst),
				.start(ch_start[g]),
				.retrig_ok(ch_retrig[g]),
				.load(ch_load[g]),
				.busy(ch_busy[g]),
				.done(ch_done[g]),
				.count(ch_count[g])
			);
		end
	endgenerate

	assign ch0_timer_interrupt = ch_done[0];
	assign ch3_timer_interrupt = ch_done[1];

	// Byte lane mask for writes.
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		logic [31:0] m;
		m = 32'h00000000;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[i*8 +: 8] = 8'hff;
			end
		end
		return m;
	endfunction

	// Merge of a write into an 8-bit register.
	function automatic logic [7:0] merge8(input logic [7:0] old,
		input logic [31:0] d, input logic [31:0] m);
		return (old & ~m[7:0]) | (d[7:0] & m[7:0]);
	endfunction

	// Merge of a write into a 16-bit register.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [31:0] m);
		return (old & ~m[15:0]) | (d[15:0] & m[15:0]);
	endfunction

	assign req = wb_cyc_i && wb_stb_i;
	// A write takes effect on the edge at which the master sees ack.
	assign wr_now = req && wb_we_i && st_reg.ack;
	assign adr = {wb_adr_i[7:2], 2'b00};
	assign wmask = lane_mask(wb_sel_i);
	assign wdat = wb_dat_i & wmask;

	always_comb begin
		st_next = st_reg;
		st_next.ack = req && !st_reg.ack;
		st_next.trig0 = 1'b0;

		// Read data is captured as ack rises; unmapped words read zero.
		if (req && !st_reg.ack) begin
			if (adr == `OSP_ADR_OUT_EN) begin
				st_next.rdata = 32'h00000000;
				st_next.rdata[`OSP_BIT_CH0] = st_reg.oe0; // R4
				st_next.rdata[`OSP_BIT_CH3] = st_reg.oe3; // R4
			end else if (adr == `OSP_ADR_OUT_BITS) begin
				st_next.rdata = 32'h00000000;
				st_next.rdata[`OSP_BIT_CH0] = st_reg.to0;
				st_next.rdata[`OSP_BIT_CH3] = st_reg.to3;
			end else if (adr == `OSP_ADR_PORT_DIR) begin
				st_next.rdata = {24'h000000, st_reg.pm3};
			end else if (adr == `OSP_ADR_IRQ_REQ) begin
				st_next.rdata = {24'h000000, st_reg.irq_request_flags_low}; // R6
			end else if (adr == `OSP_ADR_IRQ_MASK) begin
				st_next.rdata = {24'h000000, st_reg.irq_mask_flags_low};
			end else if (adr == `OSP_ADR_STATUS) begin
				st_next.rdata = 32'h00000000;
				st_next.rdata[`OSP_BIT_CH0] = st_reg.te0;
				st_next.rdata[`OSP_BIT_CH3] = st_reg.te3;
				st_next.rdata[`OSP_BIT_STAT_CH0_BUSY] = ch_busy[0];
				st_next.rdata[`OSP_BIT_STAT_CH3_BUSY] = ch_busy[1];
				st_next.rdata[`OSP_BIT_STAT_PIN_LEVEL] = pin_level;
			end else if (adr == `OSP_ADR_CH0_DATA) begin
				st_next.rdata = {16'h0000, st_reg.data0};
			end else if (adr == `OSP_ADR_CH3_DATA) begin
				st_next.rdata = {16'h0000, st_reg.data3};
			end else if (adr == `OSP_ADR_MODE) begin
				st_next.rdata = 32'h00000000;
				st_next.rdata[`OSP_BIT_MODE_CH0_RETRIG] = st_reg.retrig0;
				st_next.rdata[`OSP_BIT_MODE_CH3_RETRIG] = st_reg.retrig3;
			end else if (adr == `OSP_ADR_CH0_COUNT) begin
				st_next.rdata = {16'h0000, 16'(ch_count[0])};
			end else if (adr == `OSP_ADR_CH3_COUNT) begin
				st_next.rdata = {16'h0000, 16'(ch_count[1])};
			end else begin
				st_next.rdata = 32'h00000000;
			end
		end

		// Register writes.
		if (wr_now) begin
			if (adr == `OSP_ADR_OUT_EN) begin
				if (wmask[`OSP_BIT_CH0]) begin
					st_next.oe0 = wdat[`OSP_BIT_CH0]; // R4
				end
				if (wmask[`OSP_BIT_CH3]) begin
					st_next.oe3 = wdat[`OSP_BIT_CH3]; // R4
				end
			end else if (adr == `OSP_ADR_OUT_BITS) begin
				// Software sets a level only while counting does not own it.
				if (wmask[`OSP_BIT_CH0] && !st_reg.oe0) begin // R2 R3
					st_next.to0 = wdat[`OSP_BIT_CH0]; // R2
				end
				if (wmask[`OSP_BIT_CH3] && !st_reg.oe3) begin // R2 R3
					st_next.to3 = wdat[`OSP_BIT_CH3]; // R2
				end
			end else if (adr == `OSP_ADR_PORT_DIR) begin
				st_next.pm3 = merge8(st_reg.pm3, wb_dat_i, wmask); // R5
			end else if (adr == `OSP_ADR_IRQ_REQ) begin
				st_next.irq_request_flags_low = merge8(st_reg.irq_request_flags_low, wb_dat_i, wmask); // R7
			end else if (adr == `OSP_ADR_IRQ_MASK) begin
				st_next.irq_mask_flags_low = merge8(st_reg.irq_mask_flags_low, wb_dat_i, wmask); // R8
			end else if (adr == `OSP_ADR_START) begin
				// A 0 in a start bit does nothing; both bits may go together.
				if (wdat[`OSP_BIT_CH0]) begin // R12
					st_next.te0 = 1'b1; // R10
					st_next.trig0 = 1'b1; // R10
				end
				if (wdat[`OSP_BIT_CH3]) begin // R12
					st_next.te3 = 1'b1; // R9
				end
			end else if (adr == `OSP_ADR_CH0_DATA) begin
				st_next.data0 = merge16(st_reg.data0, wb_dat_i, wmask);
			end else if (adr == `OSP_ADR_CH3_DATA) begin
				st_next.data3 = merge16(st_reg.data3, wb_dat_i, wmask);
			end else if (adr == `OSP_ADR_MODE) begin
				if (wmask[`OSP_BIT_MODE_CH0_RETRIG]) begin
					st_next.retrig0 = wdat[`OSP_BIT_MODE_CH0_RETRIG]; // R14
				end
				if (wmask[`OSP_BIT_MODE_CH3_RETRIG]) begin
					st_next.retrig3 = wdat[`OSP_BIT_MODE_CH3_RETRIG]; // R14
				end
			end
		end

		// The master interrupt sets its flag; a set beats a clear.
		if (ch0_timer_interrupt) begin
			st_next.irq_request_flags_low[`OSP_BIT_CH0_IRQ] = 1'b1; // R6
		end

		// Master output toggles on its own interrupt when enabled.
		if (st_reg.oe0 && ch0_timer_interrupt) begin // R3
			st_next.to0 = !st_reg.to0; // R3
		end

		// Slave output: set by master irq, reset by its own; set wins.
		if (st_reg.oe3) begin // R3
			if (ch0_timer_interrupt && st_reg.te3) begin // R15
				st_next.to3 = 1'b1; // R15 R16
			end else if (ch3_timer_interrupt) begin // R15
				st_next.to3 = 1'b0; // R15
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg.ack <= 1'b0;
			st_reg.rdata <= 32'h00000000;
			st_reg.oe0 <= `OSP_RST_OUT_EN;
			st_reg.oe3 <= `OSP_RST_OUT_EN;
			st_reg.to0 <= `OSP_RST_OUT_BIT;
			st_reg.to3 <= `OSP_RST_OUT_BIT;
			st_reg.pm3 <= `OSP_RST_PORT_DIR;
			st_reg.irq_request_flags_low <= `OSP_RST_IRQ_REQ;
			st_reg.irq_mask_flags_low <= `OSP_RST_IRQ_MASK;
			st_reg.te0 <= 1'b0;
			st_reg.te3 <= 1'b0;
			st_reg.data0 <= `OSP_RST_DATA;
			st_reg.data3 <= `OSP_RST_DATA;
			st_reg.retrig0 <= `OSP_RST_RETRIG;
			st_reg.retrig3 <= `OSP_RST_RETRIG;
			st_reg.trig0 <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wb_ack_o = st_reg.ack;
	assign wb_dat_o = st_reg.rdata;
	// Output bit drives the pin only in output mode.
	assign pulse_output_pin_o = st_reg.to3; // R13 R17
	assign pulse_output_pin_oe = !st_reg.pm3[`OSP_BIT_PIN31]; // R5 R17
	assign ch0_output_bit = st_reg.to0;
	// Pending request passes when the mask bit is 0.
	assign ch0_irq_o = st_reg.irq_request_flags_low[`OSP_BIT_CH0_IRQ] &&
		!st_reg.irq_mask_flags_low[`OSP_BIT_CH0_IRQ]; // R8
endmodule

/* test/osp_top_properties.sv */
// Port-level assertions of the one-shot pulse block.
`timescale 1ns/10ps
`include "osp_params.svh"
module osp_top_properties #(
	parameter int CNT_W = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Register bus.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Pin and master outputs.
	input wire logic pulse_output_pin_i,
	input wire logic pulse_output_pin_o,
	input wire logic pulse_output_pin_oe,
	input wire logic ch0_output_bit,
	input wire logic ch0_irq_o
);
	logic wr_ok, out_wr, en3_reg, msk4_reg;
	assign wr_ok = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
	assign out_wr = wr_ok && wb_adr_i == `OSP_ADR_OUT_BITS;
	// Shadow copies tell which output rule is in force.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			en3_reg <= 1'b0;
			msk4_reg <= 1'b1;
		end else if (wr_ok && wb_adr_i == `OSP_ADR_OUT_EN) begin
			en3_reg <= wb_dat_i[`OSP_BIT_CH3];
		end else if (wr_ok && wb_adr_i == `OSP_ADR_IRQ_MASK) begin
			msk4_reg <= wb_dat_i[`OSP_BIT_CH0_IRQ];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	chk_ack_next: assert property (req_s |=> wb_ack_o) else $error("late ack");
	chk_start_zero:
		assert property (req_s ##0 (!wb_we_i && wb_adr_i == `OSP_ADR_START)
		|=> wb_dat_o == 32'h0) else $error("start register read not zero");
	chk_dir_oe:
		assert property (wr_ok && wb_adr_i == `OSP_ADR_PORT_DIR |=>
		pulse_output_pin_oe != $past(wb_dat_i[`OSP_BIT_PIN31]))
		else $error("pin drive does not follow direction bit");
	chk_mask_blocks: assert property (msk4_reg |-> !ch0_irq_o)
		else $error("interrupt passed while masked");
	chk_fixed_out:
		assert property (!$past(en3_reg) && $changed(pulse_output_pin_o)
		|-> $past(out_wr)) else $error("disabled output moved by itself");
	chk_write_ignored:
		assert property ($past(en3_reg) && $past(out_wr)
		|-> $stable(pulse_output_pin_o)) else $error("write reached output");
	chk_rise_on_irq:
		assert property ($past(en3_reg) && !msk4_reg &&
		$rose(pulse_output_pin_o) |-> ch0_irq_o) else $error("rise without irq");
endmodule
bind osp_top osp_top_properties #(.CNT_W(CNT_W)) u_osp_top_properties (
	.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .pulse_output_pin_i,
	.pulse_output_pin_o, .pulse_output_pin_oe, .ch0_output_bit, .ch0_irq_o
);

/* test/osp_load.sv */
// Load on the pulse pin: pull-up resistor and high-time meter.
`timescale 1ns/10ps
module osp_load (
	// Clock and drive from the block.
	input wire logic clk,
	input wire logic pin_o,
	input wire logic pin_oe,
	// Wire level and length of the last driven high pulse.
	output logic pin_lvl,
	output logic [15:0] width = 16'h0000
);
	logic [15:0] run = 16'h0000;
	// A released pin floats up, so it reads 1 whatever level was last driven.
	assign pin_lvl = pin_oe ? pin_o : 1'b1;
	always @(posedge clk) begin
		if (pin_oe && pin_o) begin
			run <= run + 16'h0001;
		end else if (run != 16'h0000) begin
			width <= run;
			run <= 16'h0000;
		end
	end
endmodule

/* test/tb_osp_top.sv */
// Self-checking bench of the one-shot pulse block.
`timescale 1ns/10ps
`include "osp_params.svh"
module tb_osp_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0, wb_dat_o, rd;
	logic wb_ack, pin_i, pin_o, pin_oe, ch0_bit, ch0_irq;
	logic [15:0] width;
	int n_mismatch = 0, tests_run = 0, cyc_cnt = 0, t0 = 0;
	always #10 clk = ~clk;
	always @(posedge clk) cyc_cnt <= cyc_cnt + 1;
	osp_top u_osp_top (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack), .pulse_output_pin_i(pin_i),
		.pulse_output_pin_o(pin_o), .pulse_output_pin_oe(pin_oe),
		.ch0_output_bit(ch0_bit), .ch0_irq_o(ch0_irq));
	osp_load u_osp_load (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
		.pin_lvl(pin_i), .width(width));
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask
	// One classic cycle; write lands and read data is taken at the ack edge.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'hf;
		do
			@(posedge clk);
		while (wb_ack !== 1'b1);
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		#1;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task wait_irq(input int exp);
		while (ch0_irq !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		check(cyc_cnt - t0, exp);
	endtask
	task end_of_test;
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task t_reset;
		rc(`OSP_ADR_OUT_EN, 32'h0);
		rc(`OSP_ADR_PORT_DIR, 32'hff);
		rc(`OSP_ADR_IRQ_REQ, 32'h0);
		rc(`OSP_ADR_IRQ_MASK, 32'hff);
		rc(`OSP_ADR_START, 32'h0);
		rc(8'h40, 32'h0);
		check(pin_oe, 1'b0);
		// The released pin floats high and reaches the status word.
		rc(`OSP_ADR_STATUS, 32'h100);
	endtask
	task t_fixed;
		wb(1'b1, `OSP_ADR_PORT_DIR, 32'hfd);
		check(pin_oe, 1'b1);
		wb(1'b1, `OSP_ADR_OUT_BITS, 32'h9);
		check({pin_i, ch0_bit}, 2'h3);
		wb(1'b1, `OSP_ADR_OUT_BITS, 32'h0);
		check(pin_i, 1'b0);
	endtask
	// Delay 5 and width 4: irq 8 cycles after start, pin high 6 cycles.
	task t_pulse;
		wb(1'b1, `OSP_ADR_CH0_DATA, 32'h5);
		wb(1'b1, `OSP_ADR_CH3_DATA, 32'h4);
		wb(1'b1, `OSP_ADR_OUT_EN, 32'h9);
		wb(1'b1, `OSP_ADR_OUT_BITS, 32'h8);
		wb(1'b1, `OSP_ADR_IRQ_REQ, 32'h0);
		wb(1'b1, `OSP_ADR_IRQ_MASK, 32'hef);
		wb(1'b1, `OSP_ADR_START, 32'h9);
		t0 = cyc_cnt;
		wb(1'b0, `OSP_ADR_STATUS, 32'h0);
		check(rd & 32'h9, 32'h9);
		wait_irq(8);
		repeat (12) @(posedge clk);
		check({width, pin_o, ch0_bit}, 18'h19);
		rc(`OSP_ADR_IRQ_REQ, 32'h10);
		wb(1'b1, `OSP_ADR_IRQ_MASK, 32'hff);
		check(ch0_irq, 1'b0);
	endtask
	// A second start during a 20-count delay must not move the interrupt.
	task t_retrig;
		wb(1'b1, `OSP_ADR_IRQ_REQ, 32'h0);
		wb(1'b1, `OSP_ADR_IRQ_MASK, 32'hef);
		wb(1'b1, `OSP_ADR_CH0_DATA, 32'h14);
		wb(1'b1, `OSP_ADR_START, 32'h1);
		t0 = cyc_cnt;
		wb(1'b1, `OSP_ADR_START, 32'h1);
		wait_irq(23);
		wb(1'b1, `OSP_ADR_IRQ_REQ, 32'h0);
		repeat (30) @(posedge clk);
		check(ch0_irq, 1'b0);
		// With retrigger on, the second start reloads and interrupts at once.
		wb(1'b1, `OSP_ADR_MODE, 32'h1);
		wb(1'b1, `OSP_ADR_START, 32'h1);
		t0 = cyc_cnt;
		wb(1'b1, `OSP_ADR_START, 32'h1);
		wait_irq(5);
		wb(1'b1, `OSP_ADR_PORT_DIR, 32'hff);
		check({pin_oe, pin_i}, 2'h1);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset;
		t_fixed;
		t_pulse;
		t_retrig;
		end_of_test;
	end
	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		end_of_test;
	end
endmodule
